// ==== pkg/cis_pkg.sv ====
// Constants and types shared by the instruction semantics core and its queue
package cis_pkg;
    // ************************************************************
    // Widths and sizes
    // ************************************************************
    localparam int QUEUE_BYTES = 8;
    localparam int QUEUE_PTR_W = 3;
    localparam int QUEUE_CNT_W = 4;
    localparam logic [3:0] QUEUE_FULL = 4'h8;
    localparam logic [3:0] QUEUE_WORD = 4'h2;
    localparam int RF_WORDS = 8;

    // ************************************************************
    // Values
    // ************************************************************
    localparam logic [15:0] SP_RESET = 16'h0000;
    localparam logic [15:0] RF_RESET = 16'h0000;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [15:0] MOST_NEG = 16'h8000;
    localparam logic [15:0] CNT_MAX = 16'h3fff;

    // ************************************************************
    // Opcodes
    // ************************************************************
    localparam logic [7:0] OP_NEGATE = 8'h03;
    localparam logic [7:0] OP_LDSP = 8'h10;
    localparam logic [7:0] OP_STSP = 8'h11;
    localparam logic [7:0] OP_STI = 8'hc2;
    localparam logic [7:0] OP_PUSH = 8'hc8;
    localparam logic [7:0] OP_POP = 8'hcc;
    localparam logic [7:0] OP_BLOCK_MOVE = 8'hc1;
    localparam logic [7:0] OP_BLOCK_MOVE_INT = 8'hcd;
    localparam logic [7:0] OP_RSVD = 8'hee;

    // ************************************************************
    // Operand field positions
    // ************************************************************
    localparam int ARG_A_LSB = 0;
    localparam int ARG_B_LSB = 3;

    typedef enum logic [2:0] {
        S_FETCH,
        S_DECODE,
        S_MEM,
        S_BM_RD,
        S_BM_WR
    } cis_state_t;
endpackage

// ==== rtl/cis_queue.sv ====
// Eight byte prefetch queue delivering 16-bit words
`timescale 1ns/10ps
`default_nettype none
module cis_queue (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [7:0] in_byte,
    output logic in_ready,
    output logic word_valid,
    output logic [15:0] word,
    input wire logic pop
);
    typedef struct packed {
        logic [cis_pkg::QUEUE_BYTES-1:0][7:0] mem;
        logic [cis_pkg::QUEUE_PTR_W-1:0] rd;
        logic [cis_pkg::QUEUE_PTR_W-1:0] wr;
        logic [cis_pkg::QUEUE_CNT_W-1:0] cnt;
        logic ready;
    } cis_queue_t;

    cis_queue_t q_r;
    cis_queue_t q_nxt;
    logic do_push;
    logic do_pop;

    assign word_valid = q_r.cnt >= cis_pkg::QUEUE_WORD;
    assign word = {q_r.mem[3'(q_r.rd + 3'h1)], q_r.mem[q_r.rd]};
    assign in_ready = q_r.ready;

    always_comb begin
        q_nxt = q_r;
        do_push = in_valid && q_r.ready;
        do_pop = pop && word_valid;
        if (do_push) begin
            q_nxt.mem[q_r.wr] = in_byte;
            q_nxt.wr = 3'(q_r.wr + 3'h1);
        end
        if (do_pop) begin
            q_nxt.rd = 3'(q_r.rd + 3'h2);
        end
        q_nxt.cnt = 4'(q_r.cnt + {3'h0, do_push}
                       - (do_pop ? cis_pkg::QUEUE_WORD : 4'h0));
        // Registered so the fill side never sees a combinational path
        q_nxt.ready = q_nxt.cnt != cis_pkg::QUEUE_FULL;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q_r <= '0;
            q_r.ready <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end

    queue_depth_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        q_r.cnt <= cis_pkg::QUEUE_FULL
        && (q_r.cnt != cis_pkg::QUEUE_FULL || !q_r.ready))
        else $error("Queue exceeds eight bytes");
    pop_two_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        pop && word_valid && !(in_valid && q_r.ready)
        |=> q_r.cnt == 4'($past(q_r.cnt) - cis_pkg::QUEUE_WORD))
        else $error("Word pop did not remove two bytes");
endmodule // cis_queue
`default_nettype wire

// ==== rtl/cis_core.sv ====
// Instruction execution core with prefetch queue and stack pointer
// Operation
// - Stack pointer is dedicated flip-flop register
// - Stack pointer usable as plain storage
// - Auto-increment pointer updated at instruction end
// - Negating 8000h gives 8000h, N and V
// - Opcode EEH always raises unimplemented trap
// - Block move count limited to 0000h-3FFFh
// - Block move addresses from one long register
// - Eight byte queue, 16-bit delivery path
`timescale 1ns/10ps
`default_nettype none
module cis_core (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic FETCH_VALID,
    input wire logic [7:0] FETCH_BYTE,
    output logic FETCH_READY,
    output logic MEM_REQ,
    output logic MEM_WE,
    output logic [15:0] MEM_ADDR,
    output logic [15:0] MEM_WDATA,
    input wire logic [15:0] MEM_RDATA,
    input wire logic MEM_ACK,
    output logic TRAP_UNIMP,
    output logic BLOCK_MOVE_REJECT,
    output logic FLAG_N,
    output logic FLAG_V,
    output logic FLAG_Z,
    output logic [15:0] SP_VALUE
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        cis_pkg::cis_state_t st;
        logic [7:0] op;
        logic [7:0] arg;
        logic [cis_pkg::RF_WORDS-1:0][15:0] rf;
        logic [15:0] sp;
        logic req;
        logic we;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic trap;
        logic rej;
        logic n;
        logic v;
        logic z;
    } cis_core_t;

    cis_core_t cs_r;
    cis_core_t cs_nxt;
    logic q_valid;
    logic [15:0] q_word;
    logic q_pop;
    logic [2:0] ra;
    logic [2:0] rb;
    logic [2:0] src_i;
    logic [2:0] dst_i;
    logic [15:0] negate_res;
    logic [15:0] ptr_now;
    logic [15:0] cnt_now;
    logic [15:0] src_now;

    function automatic logic is_block_move(input logic [7:0] op);
        is_block_move = (op == cis_pkg::OP_BLOCK_MOVE)
            || (op == cis_pkg::OP_BLOCK_MOVE_INT);
    endfunction

    cis_queue u_queue (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .in_valid(FETCH_VALID),
        .in_byte(FETCH_BYTE),
        .in_ready(FETCH_READY),
        .word_valid(q_valid),
        .word(q_word),
        .pop(q_pop)
    );

    assign ra = cs_r.arg[cis_pkg::ARG_A_LSB +: 3];
    assign rb = cs_r.arg[cis_pkg::ARG_B_LSB +: 3];
    // Long register: even word holds source, odd word destination
    assign src_i = {ra[2:1], 1'b0};
    assign dst_i = {ra[2:1], 1'b1};
    assign negate_res = 16'(16'h0000 - cs_r.rf[ra]);
    assign ptr_now = cs_r.rf[rb];
    assign cnt_now = cs_r.rf[rb];
    assign src_now = cs_r.rf[src_i];

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        cs_nxt = cs_r;
        q_pop = 1'b0;
        cs_nxt.trap = 1'b0;
        cs_nxt.rej = 1'b0;
        case (cs_r.st)
            cis_pkg::S_FETCH: begin
                if (q_valid) begin
                    q_pop = 1'b1;
                    cs_nxt.op = q_word[7:0];
                    cs_nxt.arg = q_word[15:8];
                    cs_nxt.st = cis_pkg::S_DECODE;
                end
            end
            cis_pkg::S_DECODE: begin
                cs_nxt.st = cis_pkg::S_FETCH;
                case (cs_r.op)
                    cis_pkg::OP_NEGATE: begin
                        cs_nxt.rf[ra] = negate_res;
                        cs_nxt.n = negate_res[15];
                        cs_nxt.v = cs_r.rf[ra] == cis_pkg::MOST_NEG;
                        cs_nxt.z = negate_res == 16'h0000;
                    end
                    cis_pkg::OP_LDSP: begin
                        cs_nxt.sp = cs_r.rf[ra];
                    end
                    cis_pkg::OP_STSP: begin
                        cs_nxt.rf[ra] = cs_r.sp;
                    end
                    cis_pkg::OP_PUSH: begin
                        cs_nxt.sp = 16'(cs_r.sp - cis_pkg::WORD_STEP);
                        cs_nxt.addr = 16'(cs_r.sp - cis_pkg::WORD_STEP);
                        cs_nxt.wdata = cs_r.rf[ra];
                        cs_nxt.we = 1'b1;
                        cs_nxt.req = 1'b1;
                        cs_nxt.st = cis_pkg::S_MEM;
                    end
                    cis_pkg::OP_POP: begin
                        cs_nxt.addr = cs_r.sp;
                        cs_nxt.we = 1'b0;
                        cs_nxt.req = 1'b1;
                        cs_nxt.st = cis_pkg::S_MEM;
                    end
                    cis_pkg::OP_STI: begin
                        // Address and data both use the old pointer
                        cs_nxt.addr = ptr_now;
                        cs_nxt.wdata = cs_r.rf[ra];
                        cs_nxt.we = 1'b1;
                        cs_nxt.req = 1'b1;
                        cs_nxt.st = cis_pkg::S_MEM;
                    end
                    cis_pkg::OP_RSVD: begin
                        cs_nxt.trap = 1'b1;
                    end
                    default: begin
                        if (is_block_move(cs_r.op)) begin
                            if (cnt_now > cis_pkg::CNT_MAX) begin
                                cs_nxt.rej = 1'b1;
                            end else if (cnt_now != 16'h0000) begin
                                cs_nxt.addr = src_now;
                                cs_nxt.we = 1'b0;
                                cs_nxt.req = 1'b1;
                                cs_nxt.st = cis_pkg::S_BM_RD;
                            end
                        end else begin
                            cs_nxt.trap = 1'b1;
                        end
                    end
                endcase
            end
            cis_pkg::S_MEM: begin
                if (MEM_ACK) begin
                    cs_nxt.req = 1'b0;
                    cs_nxt.we = 1'b0;
                    cs_nxt.st = cis_pkg::S_FETCH;
                    if (cs_r.op == cis_pkg::OP_POP) begin
                        cs_nxt.rf[ra] = MEM_RDATA;
                        cs_nxt.sp = 16'(cs_r.sp + cis_pkg::WORD_STEP);
                    end
                    if (cs_r.op == cis_pkg::OP_STI) begin
                        // Increment only once the store has completed
                        cs_nxt.rf[rb] =
                            16'(ptr_now + cis_pkg::WORD_STEP);
                    end
                end
            end
            cis_pkg::S_BM_RD: begin
                if (MEM_ACK) begin
                    cs_nxt.addr = cs_r.rf[dst_i];
                    cs_nxt.wdata = MEM_RDATA;
                    cs_nxt.we = 1'b1;
                    cs_nxt.st = cis_pkg::S_BM_WR;
                end
            end
            cis_pkg::S_BM_WR: begin
                if (MEM_ACK) begin
                    cs_nxt.rf[src_i] = 16'(src_now + cis_pkg::WORD_STEP);
                    cs_nxt.rf[dst_i] =
                        16'(cs_r.rf[dst_i] + cis_pkg::WORD_STEP);
                    cs_nxt.rf[rb] = 16'(cnt_now - 16'h0001);
                    cs_nxt.we = 1'b0;
                    if (cnt_now == 16'h0001) begin
                        cs_nxt.req = 1'b0;
                        cs_nxt.st = cis_pkg::S_FETCH;
                    end else begin
                        cs_nxt.addr = 16'(src_now + cis_pkg::WORD_STEP);
                        cs_nxt.st = cis_pkg::S_BM_RD;
                    end
                end
            end
            default: begin
                cs_nxt.st = cis_pkg::S_FETCH;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            cs_r <= '0;
            cs_r.st <= cis_pkg::S_FETCH;
            cs_r.sp <= cis_pkg::SP_RESET;
            cs_r.rf <= {cis_pkg::RF_WORDS{cis_pkg::RF_RESET}};
        end else begin
            cs_r <= cs_nxt;
        end
    end

    assign MEM_REQ = cs_r.req;
    assign MEM_WE = cs_r.we;
    assign MEM_ADDR = cs_r.addr;
    assign MEM_WDATA = cs_r.wdata;
    assign TRAP_UNIMP = cs_r.trap;
    assign BLOCK_MOVE_REJECT = cs_r.rej;
    assign FLAG_N = cs_r.n;
    assign FLAG_V = cs_r.v;
    assign FLAG_Z = cs_r.z;
    assign SP_VALUE = cs_r.sp;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    negate_most_a: assert property (
        cs_r.st == cis_pkg::S_DECODE && cs_r.op == cis_pkg::OP_NEGATE
        && cs_r.rf[ra] == cis_pkg::MOST_NEG
        |=> FLAG_N && FLAG_V && !FLAG_Z
        && cs_r.rf[$past(ra)] == cis_pkg::MOST_NEG)
        else $error("Negate of most negative word wrong");
    rsvd_trap_a: assert property (
        cs_r.st == cis_pkg::S_DECODE && cs_r.op == cis_pkg::OP_RSVD
        |=> TRAP_UNIMP ##1 !TRAP_UNIMP)
        else $error("Reserved opcode did not trap");
    sti_addr_a: assert property (
        cs_r.st == cis_pkg::S_DECODE && cs_r.op == cis_pkg::OP_STI
        |=> MEM_REQ && MEM_WE && MEM_ADDR == $past(ptr_now)
        && MEM_WDATA == $past(cs_r.rf[ra]))
        else $error("Indirect store used a changed pointer");
    sti_late_inc_a: assert property (
        cs_r.st == cis_pkg::S_MEM && cs_r.op == cis_pkg::OP_STI
        |=> ptr_now == 16'($past(ptr_now)
        + ($past(MEM_ACK) ? cis_pkg::WORD_STEP : 16'h0000)))
        else $error("Pointer updated before store completed");
    sp_hold_a: assert property (
        cs_r.st == cis_pkg::S_FETCH |=> $stable(SP_VALUE))
        else $error("Stack pointer changed while idle");
    push_sp_a: assert property (
        cs_r.st == cis_pkg::S_DECODE && cs_r.op == cis_pkg::OP_PUSH
        |=> SP_VALUE == 16'($past(SP_VALUE) - cis_pkg::WORD_STEP)
        && MEM_ADDR == SP_VALUE)
        else $error("Push did not predecrement stack pointer");
    cnt_reject_a: assert property (
        cs_r.st == cis_pkg::S_DECODE && is_block_move(cs_r.op)
        && cnt_now > cis_pkg::CNT_MAX
        |=> BLOCK_MOVE_REJECT && !MEM_REQ && cs_r.rf == $past(cs_r.rf))
        else $error("Oversized block move count accepted");
    block_src_a: assert property (
        cs_r.st == cis_pkg::S_DECODE && is_block_move(cs_r.op)
        && cnt_now != 16'h0000 && cnt_now <= cis_pkg::CNT_MAX
        |=> MEM_REQ && !MEM_WE && MEM_ADDR == $past(src_now))
        else $error("Block move source address wrong");

    negate_most_c: cover property (cs_r.st == cis_pkg::S_DECODE
        && cs_r.op == cis_pkg::OP_NEGATE
        && cs_r.rf[ra] == cis_pkg::MOST_NEG);
    block_done_c: cover property (cs_r.st == cis_pkg::S_BM_WR && MEM_ACK
        && cs_r.rf[rb] == 16'h0001);
    trap_c: cover property (TRAP_UNIMP);
    sti_done_c: cover property (cs_r.st == cis_pkg::S_MEM
        && cs_r.op == cis_pkg::OP_STI && MEM_ACK);
endmodule // cis_core
`default_nettype wire

// ==== dv/cis_mem_model.sv ====
// Word-wide external memory model for the core's memory port
`timescale 1ns/10ps
`default_nettype none
module cis_mem_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req,
    input wire logic we,
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [3:0] lat,
    output logic [15:0] rdata,
    output logic ack
);
    logic [15:0] mem [0:255];
    logic [3:0] wait_r;
    always @(posedge clk) begin
        if (!rst_n) begin
            ack <= 1'b0;
            wait_r <= 4'h0;
            rdata <= 16'h0000;
        end else if (ack) begin
            // Read data is not held past the answer cycle
            ack <= 1'b0;
            rdata <= ~rdata;
            if (we) begin
                mem[addr[8:1]] <= wdata;
            end
        end else if (req && wait_r == lat) begin
            ack <= 1'b1;
            wait_r <= 4'h0;
            rdata <= we ? ~rdata : mem[addr[8:1]];
        end else if (req) begin
            wait_r <= wait_r + 4'h1;
        end
    end
endmodule // cis_mem_model
`default_nettype wire

// ==== dv/cpu_instruction_semantics_test.sv ====
// Self-checking bench for the instruction semantics core
`timescale 1ns/10ps
`default_nettype none
module cpu_instruction_semantics_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic fv = 1'b0;
    logic [7:0] fb = 8'h00;
    logic [3:0] lat = 4'h0;
    logic fr, req, we, ack, trap, rej, fn, fvf, fz;
    logic [15:0] addr, wdata, rdata, sp;
    int failures = 0;
    int total_checks = 0;
    int traps = 0;
    int rejs = 0;
    int reqs = 0;
    always #10 clk = ~clk;
    cis_core dut_u (.SYS_CLK(clk), .RST_N(rst_n), .FETCH_VALID(fv),
        .FETCH_BYTE(fb), .FETCH_READY(fr), .MEM_REQ(req), .MEM_WE(we),
        .MEM_ADDR(addr), .MEM_WDATA(wdata), .MEM_RDATA(rdata),
        .MEM_ACK(ack), .TRAP_UNIMP(trap), .BLOCK_MOVE_REJECT(rej),
        .FLAG_N(fn), .FLAG_V(fvf), .FLAG_Z(fz), .SP_VALUE(sp));
    cis_mem_model mem_u (.clk(clk), .rst_n(rst_n), .req(req), .we(we),
        .addr(addr), .wdata(wdata), .lat(lat), .rdata(rdata), .ack(ack));
    always @(posedge clk) begin
        traps += (trap === 1'b1);
        rejs += (rej === 1'b1);
        reqs += (req === 1'b1 && ack === 1'b1);
    end
    // ************************************************************
    // Helpers
    // ************************************************************
    task tick();
        @(posedge clk);
        #1;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task report_and_stop();
        if (failures == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task put_byte(input logic [7:0] b);
        int n;
        n = 0;
        fb = b;
        fv = 1'b1;
        while (fr !== 1'b1 && n < 50) begin
            tick();
            n++;
        end
        if (n >= 50) begin
            failures++;
        end
        tick();
    endtask
    // Waits out the decode, then any memory traffic
    task exec(input logic [7:0] op, input logic [7:0] arg);
        int n;
        n = 0;
        put_byte(op);
        put_byte(arg);
        fv = 1'b0;
        repeat (5) tick();
        while (req !== 1'b0 && n < 300) begin
            tick();
            n++;
        end
        if (n >= 300) begin
            failures++;
        end
        repeat (2) tick();
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task t_load_regs();
        for (int i = 0; i < 8; i++) begin
            exec(cis_pkg::OP_POP, 8'(i));
            chk(sp, 16'(2 * i + 2));
        end
    endtask
    task t_autoinc();
        int cnt;
        logic r;
        exec(cis_pkg::OP_STI, 8'h00);
        chk(mem_u.mem[8'h80], 16'h0100);
        lat = 4'hf;
        put_byte(cis_pkg::OP_STI);
        put_byte(8'h00);
        fv = 1'b0;
        repeat (3) tick();
        cnt = 0;
        // Queue must stop taking bytes while the store stalls
        for (int i = 0; i < 12; i++) begin
            fb = cnt[0] ? 8'h02 : cis_pkg::OP_NEGATE;
            fv = 1'b1;
            r = fr;
            tick();
            cnt += (r === 1'b1);
        end
        fv = 1'b0;
        chk(16'(cnt), 16'h0008);
        chk({15'h0, fr}, 16'h0000);
        repeat (40) tick();
        lat = 4'h0;
        chk(mem_u.mem[8'h81], 16'h0102);
        chk({15'h0, fr}, 16'h0001);
    endtask
    task t_negate();
        exec(cis_pkg::OP_NEGATE, 8'h01);
        chk({13'h0, fn, fvf, fz}, 16'h0006);
        exec(cis_pkg::OP_NEGATE, 8'h02);
        chk({13'h0, fn, fvf, fz}, 16'h0001);
        exec(cis_pkg::OP_PUSH, 8'h01);
        chk(sp, 16'h000e);
        chk(mem_u.mem[8'h07], 16'h8000);
    endtask
    task t_block_move();
        lat = 4'h2;
        // Earlier scenarios left their accesses in the counter
        reqs = 0;
        exec(cis_pkg::OP_BLOCK_MOVE, 8'h1e);
        chk(mem_u.mem[8'h30], 16'ha5a5);
        chk(mem_u.mem[8'h31], 16'h5a5a);
        chk(16'(reqs), 16'h0004);
        // Zero count in r4: accepted, but no access at all
        exec(cis_pkg::OP_BLOCK_MOVE, 8'h26);
        chk(16'(reqs), 16'h0004);
        chk(16'(rejs), 16'h0000);
        exec(cis_pkg::OP_BLOCK_MOVE_INT, 8'h2e);
        chk(16'(rejs), 16'h0001);
        chk(16'(reqs), 16'h0004);
        exec(cis_pkg::OP_PUSH, 8'h06);
        chk(mem_u.mem[8'h06], 16'h0044);
        lat = 4'h0;
    endtask
    task t_trap();
        reqs = 0;
        exec(cis_pkg::OP_RSVD, 8'h00);
        exec(cis_pkg::OP_RSVD, 8'h3f);
        // Any other undecoded opcode traps as well
        exec(8'h55, 8'h00);
        chk(16'(traps), 16'h0003);
        chk(16'(reqs), 16'h0000);
    endtask
    task t_sp_storage();
        exec(cis_pkg::OP_LDSP, 8'h01);
        chk(sp, 16'h8000);
        exec(cis_pkg::OP_STSP, 8'h04);
        exec(cis_pkg::OP_PUSH, 8'h04);
        chk(sp, 16'h7ffe);
        chk(mem_u.mem[8'hff], 16'h8000);
    endtask
    initial begin
        // Pointer, most negative word, zero, counts, block addresses
        mem_u.mem[0] = 16'h0100;
        mem_u.mem[1] = 16'h8000;
        mem_u.mem[2] = 16'h0000;
        mem_u.mem[3] = 16'h0002;
        mem_u.mem[4] = 16'h0000;
        mem_u.mem[5] = 16'h4000;
        mem_u.mem[6] = 16'h0040;
        mem_u.mem[7] = 16'h0060;
        mem_u.mem[8'h20] = 16'ha5a5;
        mem_u.mem[8'h21] = 16'h5a5a;
        repeat (4) tick();
        chk(sp, cis_pkg::SP_RESET);
        chk({15'h0, fr}, 16'h0001);
        rst_n = 1'b1;
        tick();
        t_load_regs();
        t_autoinc();
        t_negate();
        t_block_move();
        t_trap();
        t_sp_storage();
        report_and_stop();
    end
    initial begin
        #200000;
        failures++;
        report_and_stop();
    end
endmodule // cpu_instruction_semantics_test
`default_nettype wire
